/* src/mpcs_map.svh */
`ifndef MPCS_MAP_SVH
`define MPCS_MAP_SVH

// Word offsets on the register bus (index); byte address is four times these
`define MPCS_OFS_CTRL      6'h17
`define MPCS_OFS_STATUS    6'h18
`define MPCS_OFS_ADV       6'h19
`define MPCS_OFS_LP        6'h1A
`define MPCS_OFS_ALIGN     6'h1B
`define MPCS_OFS_GOOD      6'h1C
`define MPCS_OFS_ERR       6'h1D

// Control register fields
`define MPCS_CTRL_PDET_BIT   13
`define MPCS_CTRL_FORCE_BIT  11
`define MPCS_CTRL_RST        16'h1010

// Status register fields
`define MPCS_ST_SYNC_BIT     15
`define MPCS_ST_CGBAD_BIT    14
`define MPCS_ST_LINK100_BIT  13
`define MPCS_ST_LINK10_BIT   12
`define MPCS_ST_RESTART_BIT  11
`define MPCS_ST_RF_HI        9
`define MPCS_ST_RF_LO        8

// Alignment status fields
`define MPCS_AL_REALIGN_BIT  15
`define MPCS_AL_SIGDET_BIT   14
`define MPCS_AL_FAR_FAULT_BIT 13
`define MPCS_AL_COMMA_BIT    12
`define MPCS_AL_POS_HI       11
`define MPCS_AL_POS_LO       8
`define MPCS_AL_HALT_BIT     7
`define MPCS_AL_POS_MAX      4'h9

// Counters
`define MPCS_GOOD_WRAP       14'h2710
`define MPCS_ERR_SAT         8'hFF
`define MPCS_SEL_MEDIA       2'h0
`define MPCS_SEL_MAC         2'h1
`define MPCS_ADV_RST         16'h0000

`endif

/* src/mpcs_pkg.sv */
package mpcs_pkg;

    // Live indications from the media PCS
    typedef struct packed {
        logic       sync_lost;
        logic       cg_bad;
        logic       link_100;
        logic       link_10;
        logic       lp_restart;
        logic [1:0] lp_remote_fault;
        logic       lp_asym_pause;
        logic       lp_sym_pause;
        logic       lp_full_duplex;
        logic       lp_half_duplex;
        logic       lp_an_capable;
        logic       link_up;
        logic       an_complete;
        logic       signal_detect;
    } mpcs_pcs_s;

    typedef struct packed {
        logic       realign;
        logic       comma_seen;
        logic [3:0] comma_pos;
        logic       far_end_fault_indication;
        logic       halt_line_state;
    } mpcs_align_s;

    // One-cycle packet events per SerDes
    typedef struct packed {
        logic good;
        logic bad;
    } mpcs_pkt_s;

    typedef enum logic [1:0] {
        MPCS_IDLE,
        MPCS_ANSWER
    } mpcs_bus_e;

endpackage

/* src/mpcs_regs.sv */
// Operation
// - Parallel detect acts only with negotiation enabled and full duplex advertised.
// - Status bit 15 latches sync loss since last read.
// - Status bit 14 latches invalid code-group since last read.
// - Bits 13 and 12 show 100 Mb/FX and 10 Mb link status.
// - Bit 11 shows partner requested negotiation restart.
// - Bits 9:8 nonzero when partner signals remote fault.
// - Bits 7..3 show partner pause, duplex and negotiation abilities.
// - Bits 2..0 show link up, negotiation complete, signal detect.
// - Advertised word writable and readable only when force bit set; resets zero.
// - Advertised word reads undefined without force bit; returns zero here.
// - Partner word holds last configuration code word received.
// - Alignment bit 15 flags comma realignment, clears on read.
// - Alignment bit 14 is sticky signal detect, clears on read.
// - Alignment bit 13 latches far-end fault indication since last read.
// - Comma bit 12 sticky, clears without comma, set to 1 on read.
// - Bits 11:8 give comma position, 0 through 9 only.
// - Alignment bit 7 latches halt line state since last read.
// - Good counter bit 15 flags packet since last read, clears on read.
// - Good counter counts valid CRC, wraps at 10000, clears on read.
// - Select 00 routes media counters, 01 MAC counters.
// - Error counter saturates at FF, clears on read.
// - Counters count only while media link is up.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mpcs_map.svh"

module mpcs_regs #(
    parameter int ADDR_W = 6
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire mpcs_pkg::mpcs_pcs_s  pcs,
    input  wire mpcs_pkg::mpcs_align_s align,
    input  wire logic                 lp_word_valid,
    input  wire logic [15:0]          lp_word,
    input  wire mpcs_pkg::mpcs_pkt_s  pkt_media,
    input  wire mpcs_pkg::mpcs_pkt_s  pkt_mac,
    output logic      [15:0]          adv_word,
    output logic                      parallel_detect_en,
    input  wire logic                 an_enable
);

    initial begin
        if (ADDR_W < 6) $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Every access takes exactly one wait cycle: waitrequest is high in the
    // request cycle, low in the next, so read data always comes from a flop.
    mpcs_pkg::mpcs_bus_e state_q;
    logic                rd_hit;
    logic                wr_hit;
    logic [15:0]         rd_word;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= mpcs_pkg::MPCS_IDLE;
        end else begin
            unique case (state_q)
                mpcs_pkg::MPCS_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_q <= mpcs_pkg::MPCS_ANSWER;
                    end
                end
                mpcs_pkg::MPCS_ANSWER: begin
                    state_q <= mpcs_pkg::MPCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(state_q == mpcs_pkg::MPCS_IDLE && (avs_read || avs_write));
        end
    end

    // Completion strobes: effect happens in the answer cycle
    assign rd_hit = (state_q == mpcs_pkg::MPCS_ANSWER) && avs_read;
    assign wr_hit = (state_q == mpcs_pkg::MPCS_ANSWER) && avs_write;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    logic rd_status;
    logic rd_align;
    logic rd_good;
    logic rd_err;
    logic wr_lo;
    logic wr_hi;
    assign rd_status = rd_hit && hit(avs_address, `MPCS_OFS_STATUS);
    assign rd_align  = rd_hit && hit(avs_address, `MPCS_OFS_ALIGN);
    assign rd_good   = rd_hit && hit(avs_address, `MPCS_OFS_GOOD);
    assign rd_err    = rd_hit && hit(avs_address, `MPCS_OFS_ERR);
    assign wr_lo     = wr_hit && avs_byteenable[0];
    assign wr_hi     = wr_hit && avs_byteenable[1];

    // ------------------------------------------------------------
    // Control and advertised word
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] adv_q;
    logic        force_adv;
    assign force_adv = ctrl_q[`MPCS_CTRL_FORCE_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `MPCS_CTRL_RST;
        end else if (wr_hit && hit(avs_address, `MPCS_OFS_CTRL)) begin
            if (wr_lo) ctrl_q[7:0]  <= avs_writedata[7:0];
            if (wr_hi) ctrl_q[15:8] <= avs_writedata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_q <= `MPCS_ADV_RST;
        end else if (wr_hit && hit(avs_address, `MPCS_OFS_ADV) && force_adv) begin
            if (wr_lo) adv_q[7:0]  <= avs_writedata[7:0];
            if (wr_hi) adv_q[15:8] <= avs_writedata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_word           <= `MPCS_ADV_RST;
            parallel_detect_en <= 1'b0;
        end else begin
            adv_word           <= adv_q;
            // Parallel detect is gated by negotiation and full-duplex advertisement
            parallel_detect_en <= ctrl_q[`MPCS_CTRL_PDET_BIT] && an_enable
                                  && adv_q[5];
        end
    end

    // ------------------------------------------------------------
    // Partner code word
    // ------------------------------------------------------------
    logic [15:0] lp_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_q <= 16'h0000;
        end else if (lp_word_valid) begin
            lp_q <= lp_word;
        end
    end

    // ------------------------------------------------------------
    // Latched indications: set wins over the read clear
    // ------------------------------------------------------------
    logic sync_lat_q;
    logic cgbad_lat_q;
    logic realign_q;
    logic sigdet_q;
    logic far_fault_q;
    logic comma_q;
    logic halt_line_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_lat_q  <= 1'b0;
            cgbad_lat_q <= 1'b0;
        end else begin
            sync_lat_q  <= pcs.sync_lost || (sync_lat_q && !rd_status);
            cgbad_lat_q <= pcs.cg_bad || (cgbad_lat_q && !rd_status);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            realign_q <= 1'b0;
            sigdet_q  <= 1'b0;
            far_fault_q <= 1'b0;
            halt_line_q <= 1'b0;
        end else begin
            realign_q   <= align.realign || (realign_q && !rd_align);
            sigdet_q    <= pcs.signal_detect || (sigdet_q && !rd_align);
            far_fault_q <= align.far_end_fault_indication || (far_fault_q && !rd_align);
            halt_line_q <= align.halt_line_state || (halt_line_q && !rd_align);
        end
    end

    // Comma bit re-arms to 1 on read and drops whenever no comma is seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comma_q <= 1'b1;
        end else if (!align.comma_seen) begin
            comma_q <= 1'b0;
        end else if (rd_align) begin
            comma_q <= 1'b1;
        end
    end

    // Out-of-range positions leave the last in-range position shown
    logic [3:0] pos_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= 4'h0;
        end else if (align.comma_pos <= `MPCS_AL_POS_MAX) begin
            pos_q <= align.comma_pos;
        end
    end

    // ------------------------------------------------------------
    // Receive counters, one set per SerDes
    // ------------------------------------------------------------
    logic [1:0]  sel_q;
    logic [13:0] good_q [2];
    logic [7:0]  err_q  [2];
    logic        seen_q [2];
    mpcs_pkg::mpcs_pkt_s pkt [2];
    assign pkt[0] = pkt_media;
    assign pkt[1] = pkt_mac;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `MPCS_SEL_MEDIA;
        end else if (wr_hit && hit(avs_address, `MPCS_OFS_ERR) && wr_hi) begin
            sel_q <= avs_writedata[15:14];
        end
    end

    // Reserved select codes route nothing, so no counter is cleared by them
    logic sel_ok [2];
    assign sel_ok[0] = (sel_q == `MPCS_SEL_MEDIA);
    assign sel_ok[1] = (sel_q == `MPCS_SEL_MAC);

    for (genvar i = 0; i < 2; i++) begin : g_cnt
        logic cnt_en;
        assign cnt_en = pcs.link_up;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                good_q[i] <= 14'h0000;
                seen_q[i] <= 1'b0;
            end else begin
                if (rd_good && sel_ok[i]) begin
                    good_q[i] <= (cnt_en && pkt[i].good) ? 14'h0001 : 14'h0000;
                end else if (cnt_en && pkt[i].good) begin
                    good_q[i] <= (good_q[i] == `MPCS_GOOD_WRAP - 14'h0001)
                                 ? 14'h0000 : good_q[i] + 14'h0001;
                end
                seen_q[i] <= (cnt_en && pkt[i].good)
                             || (seen_q[i] && !(rd_good && sel_ok[i]));
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                err_q[i] <= 8'h00;
            end else if (rd_err && sel_ok[i]) begin
                err_q[i] <= (cnt_en && pkt[i].bad) ? 8'h01 : 8'h00;
            end else if (cnt_en && pkt[i].bad && err_q[i] != `MPCS_ERR_SAT) begin
                err_q[i] <= err_q[i] + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [15:0] st_word;
    logic [15:0] al_word;
    logic [15:0] good_word;
    logic [15:0] err_word;
    logic        m;
    assign m = (sel_q == `MPCS_SEL_MAC);

    always_comb begin
        st_word = 16'h0000;
        st_word[`MPCS_ST_SYNC_BIT]    = sync_lat_q;
        st_word[`MPCS_ST_CGBAD_BIT]   = cgbad_lat_q;
        st_word[`MPCS_ST_LINK100_BIT] = pcs.link_100;
        st_word[`MPCS_ST_LINK10_BIT]  = pcs.link_10;
        st_word[`MPCS_ST_RESTART_BIT] = pcs.lp_restart;
        st_word[`MPCS_ST_RF_HI:`MPCS_ST_RF_LO] = pcs.lp_remote_fault;
        st_word[7:3] = {pcs.lp_asym_pause, pcs.lp_sym_pause, pcs.lp_full_duplex,
                        pcs.lp_half_duplex, pcs.lp_an_capable};
        st_word[2:0] = {pcs.link_up, pcs.an_complete, pcs.signal_detect};
        al_word = 16'h0000;
        al_word[`MPCS_AL_REALIGN_BIT] = realign_q;
        al_word[`MPCS_AL_SIGDET_BIT]  = sigdet_q;
        al_word[`MPCS_AL_FAR_FAULT_BIT] = far_fault_q;
        al_word[`MPCS_AL_COMMA_BIT]   = comma_q;
        al_word[`MPCS_AL_POS_HI:`MPCS_AL_POS_LO] = pos_q;
        al_word[`MPCS_AL_HALT_BIT]    = halt_line_q;
        good_word = 16'h0000;
        err_word  = {sel_q, 14'h0000};
        if (sel_ok[0] || sel_ok[1]) begin
            good_word = {seen_q[m], 1'b0, good_q[m]};
            err_word  = {sel_q, 6'h00, err_q[m]};
        end
        rd_word = 16'h0000;
        unique case (avs_address)
            ADDR_W'(`MPCS_OFS_CTRL):   rd_word = ctrl_q;
            ADDR_W'(`MPCS_OFS_STATUS): rd_word = st_word;
            ADDR_W'(`MPCS_OFS_ADV):    rd_word = force_adv ? adv_q : 16'h0000;
            ADDR_W'(`MPCS_OFS_LP):     rd_word = lp_q;
            ADDR_W'(`MPCS_OFS_ALIGN):  rd_word = al_word;
            ADDR_W'(`MPCS_OFS_GOOD):   rd_word = good_word;
            ADDR_W'(`MPCS_OFS_ERR):    rd_word = err_word;
            default:                   rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (state_q == mpcs_pkg::MPCS_IDLE && avs_read) begin
            avs_readdata <= {16'h0000, rd_word};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sync_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        pcs.sync_lost |=> sync_lat_q) else $error("sync loss not latched");
    cgbad_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        pcs.cg_bad |=> cgbad_lat_q) else $error("bad code-group not latched");
    read_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_align && align.halt_line_state) |=> halt_line_q) else $error("event lost on read");
    comma_rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_align && align.comma_seen) |=> comma_q) else $error("comma not re-armed");
    pos_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_q <= `MPCS_AL_POS_MAX) else $error("comma position out of range");
    good_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        good_q[0] < `MPCS_GOOD_WRAP) else $error("good counter passed wrap");
    err_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (err_q[0] == `MPCS_ERR_SAT && !(rd_err && sel_ok[0])) |=> err_q[0] == `MPCS_ERR_SAT)
        else $error("error counter left saturation");
    link_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!pcs.link_up && !rd_good) |=> $stable(good_q[0])) else $error("counted with link down");
    adv_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        !force_adv |=> $stable(adv_q)) else $error("advertised word written while locked");
    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == mpcs_pkg::MPCS_IDLE && avs_read) |=> !avs_waitrequest)
        else $error("read not answered in one cycle");
    wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest) else $error("answer held past one cycle");
    realign_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        align.realign |=> realign_q) else $error("realignment not latched");
    sigdet_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        pcs.signal_detect |=> sigdet_q) else $error("signal detect not latched");
    far_fault_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        align.far_end_fault_indication |=> far_fault_q) else $error("far fault not latched");
    halt_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        align.halt_line_state |=> halt_line_q) else $error("halt line not latched");
    comma_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        !align.comma_seen |=> !comma_q) else $error("comma bit kept without comma");
    good_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pcs.link_up && pkt_media.good) |=> seen_q[0]) else $error("packet flag not set");
    err_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_err && sel_ok[0] && !pkt_media.bad) |=> err_q[0] == 8'h00)
        else $error("error counter not cleared by read");
    lp_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        lp_word_valid |=> lp_q == $past(lp_word)) else $error("partner word not stored");
    pd_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !an_enable |=> !parallel_detect_en) else $error("parallel detect without negotiation");

endmodule

/* verif/mpcs_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Far-side PCS status and packet source
// ----------------------------------------
module mpcs_partner (
    input  wire logic            clk,
    output mpcs_pkg::mpcs_pcs_s   pcs,
    output mpcs_pkg::mpcs_align_s align,
    output logic                  lp_word_valid,
    output logic [15:0]           lp_word,
    output mpcs_pkg::mpcs_pkt_s   pkt_media,
    output mpcs_pkg::mpcs_pkt_s   pkt_mac
);
    initial begin
        pcs           = '0;
        align         = '0;
        lp_word_valid = 1'b0;
        lp_word       = 16'h0000;
        pkt_media     = '0;
        pkt_mac       = '0;
    end

    // One call holds the new levels for at least one cycle
    task automatic set_status(input mpcs_pkg::mpcs_pcs_s s, input mpcs_pkg::mpcs_align_s a);
        @(posedge clk);
        pcs   <= s;
        align <= a;
    endtask

    // Word is invalid outside its cycle, so show its inverse to catch late capture
    task automatic send_word(input logic [15:0] w);
        @(posedge clk);
        lp_word_valid <= 1'b1;
        lp_word       <= w;
        @(posedge clk);
        lp_word_valid <= 1'b0;
        lp_word       <= ~w;
    endtask

    // Back-to-back packet events, one per cycle
    task automatic send_pkts(input logic mac, input logic bad, input int n);
        repeat (n) begin
            @(posedge clk);
            if (mac) begin
                pkt_mac <= {!bad, bad};
            end else begin
                pkt_media <= {!bad, bad};
            end
        end
        @(posedge clk);
        pkt_mac   <= '0;
        pkt_media <= '0;
    endtask
endmodule

/* verif/test_media_serdes_pcs_status_counters.sv */
`timescale 1ns/1ps
`include "mpcs_map.svh"
module test_media_serdes_pcs_status_counters;
    logic                  clk;
    logic                  rst_n;
    logic [5:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic                  an_enable;
    logic [15:0]           adv_word;
    logic                  parallel_detect_en;
    mpcs_pkg::mpcs_pcs_s   pcs;
    mpcs_pkg::mpcs_align_s align;
    logic                  lp_word_valid;
    logic [15:0]           lp_word;
    mpcs_pkg::mpcs_pkt_s   pkt_media;
    mpcs_pkg::mpcs_pkt_s   pkt_mac;
    logic [31:0]           rd;
    logic [14:0]           p;
    int                    n_errors;
    int                    checked;
    int                    cycles;

    mpcs_regs mpcs_regs_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pcs(pcs), .align(align),
        .lp_word_valid(lp_word_valid), .lp_word(lp_word), .pkt_media(pkt_media),
        .pkt_mac(pkt_mac), .adv_word(adv_word), .parallel_detect_en(parallel_detect_en),
        .an_enable(an_enable));

    mpcs_partner mpcs_partner_i (.clk(clk), .pcs(pcs), .align(align),
        .lp_word_valid(lp_word_valid), .lp_word(lp_word), .pkt_media(pkt_media),
        .pkt_mac(pkt_mac));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // About 10400 cycles of traffic; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Bus access and checking
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] wd,
                       input logic [3:0] be, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= a;
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= {16'h0000, wd};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b1, 1'b0);
        end
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] wd);
        bus(1'b1, a, wd, 4'h3, rd);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000, 4'h3, rd);
        chk(rd, {16'h0000, exp});
    endtask

    task automatic stop_test();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_errors = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        an_enable = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`MPCS_OFS_ADV, `MPCS_ADV_RST);
        rdc(`MPCS_OFS_CTRL, `MPCS_CTRL_RST);
        rdc(`MPCS_OFS_GOOD, 16'h0000);
        rdc(6'h05, 16'h0000);
        // Advertised word is locked until the force bit is set
        wr(`MPCS_OFS_ADV, 16'hA5A5);
        rdc(`MPCS_OFS_ADV, 16'h0000);
        wr(`MPCS_OFS_CTRL, 16'h1810);
        wr(`MPCS_OFS_ADV, 16'hA5A5);
        rdc(`MPCS_OFS_ADV, 16'hA5A5);
        bus(1'b1, `MPCS_OFS_ADV, 16'h0020, 4'h1, rd);
        rdc(`MPCS_OFS_ADV, 16'hA520);
        chk({16'h0000, adv_word}, 32'h0000_A520);
        // Parallel detect needs negotiation and full duplex advertised
        wr(`MPCS_OFS_CTRL, 16'h3810);
        an_enable <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, parallel_detect_en}, 32'h1);
        an_enable <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, parallel_detect_en}, 32'h0);
        an_enable <= 1'b1;
        wr(`MPCS_OFS_ADV, 16'hA500);
        repeat (3) @(posedge clk);
        chk({31'h0, parallel_detect_en}, 32'h0);
        // Live status fields, two patterns complementary except link up (one in both), sync loss and bad code-group (zero in both)
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 15'h16AD : 15'h0956;
            mpcs_partner_i.set_status(p, '0);
            rdc(`MPCS_OFS_STATUS, {p[14:10], 1'b0, p[9:0]});
        end
        // Latched status: a held event survives the clearing read
        mpcs_partner_i.set_status(15'h2004, '0);
        mpcs_partner_i.set_status(15'h0004, '0);
        rdc(`MPCS_OFS_STATUS, 16'h4004);
        rdc(`MPCS_OFS_STATUS, 16'h0004);
        mpcs_partner_i.set_status(15'h4004, '0);
        rdc(`MPCS_OFS_STATUS, 16'h8004);
        rdc(`MPCS_OFS_STATUS, 16'h8004);
        mpcs_partner_i.set_status(15'h0004, '0);
        rdc(`MPCS_OFS_STATUS, 16'h8004);
        rdc(`MPCS_OFS_STATUS, 16'h0004);
        mpcs_partner_i.send_word(16'h1234);
        mpcs_partner_i.send_word(16'hBEEF);
        rdc(`MPCS_OFS_LP, 16'hBEEF);
        // Alignment: one-cycle events, then comma loss and a bad position
        mpcs_partner_i.set_status(15'h0005, 9'b1_1_0111_1_1);
        // Comma bit dropped while no comma was seen; only a read re-arms it
        mpcs_partner_i.set_status(15'h0004, 9'b0_1_0111_0_1);
        rdc(`MPCS_OFS_ALIGN, 16'hE780);
        rdc(`MPCS_OFS_ALIGN, 16'h1780);
        mpcs_partner_i.set_status(15'h0004, 9'b0_0_1100_0_0);
        rdc(`MPCS_OFS_ALIGN, 16'h0780);
        // Counters with link up
        mpcs_partner_i.send_pkts(1'b0, 1'b0, 10002);
        rdc(`MPCS_OFS_GOOD, 16'h8002);
        rdc(`MPCS_OFS_GOOD, 16'h0000);
        mpcs_partner_i.send_pkts(1'b0, 1'b1, 260);
        rdc(`MPCS_OFS_ERR, 16'h00FF);
        rdc(`MPCS_OFS_ERR, 16'h0000);
        wr(`MPCS_OFS_ERR, 16'h4000);
        mpcs_partner_i.send_pkts(1'b1, 1'b0, 3);
        mpcs_partner_i.send_pkts(1'b1, 1'b1, 2);
        mpcs_partner_i.send_pkts(1'b0, 1'b0, 4);
        rdc(`MPCS_OFS_GOOD, 16'h8003);
        rdc(`MPCS_OFS_ERR, 16'h4002);
        wr(`MPCS_OFS_ERR, 16'h0000);
        rdc(`MPCS_OFS_GOOD, 16'h8004);
        wr(`MPCS_OFS_ERR, 16'h8000);
        rdc(`MPCS_OFS_ERR, 16'h8000);
        rdc(`MPCS_OFS_GOOD, 16'h0000);
        // Link down: nothing counts
        wr(`MPCS_OFS_ERR, 16'h0000);
        mpcs_partner_i.set_status(15'h0000, '0);
        mpcs_partner_i.send_pkts(1'b0, 1'b0, 5);
        mpcs_partner_i.send_pkts(1'b0, 1'b1, 5);
        rdc(`MPCS_OFS_GOOD, 16'h0000);
        rdc(`MPCS_OFS_ERR, 16'h0000);
        stop_test();
    end
endmodule
